//--- ifc_pkg.sv
package ifc_pkg;
   // Word indices of the register map; byte address is index times four
   localparam logic [3:0] IFC_IDX_FC  = 4'h0;  // flash_control
   localparam logic [3:0] IFC_IDX_RK  = 4'h1;  // chip_reset_key
   localparam logic [3:0] IFC_IDX_TB  = 4'h2;  // timing_and_buffer_clear
   localparam logic [3:0] IFC_IDX_AL  = 4'h3;  // flash_address_low
   localparam logic [3:0] IFC_IDX_AH  = 4'h4;  // flash_address_high
   localparam logic [3:0] IFC_IDX_D0L = 4'h5;  // data_word0_low, then 0H,1L,1H..3H
   localparam logic [3:0] IFC_IDX_D3H = 4'hc;  // data_word3_high, last mapped word
   // Field positions in flash_control
   localparam int IFC_B_EN  = 7;
   localparam int IFC_B_MH  = 6;
   localparam int IFC_B_ML  = 4;
   localparam int IFC_B_TRG = 3;
   localparam int IFC_B_PS  = 2;
   localparam int IFC_B_RE  = 1;
   localparam int IFC_B_RS  = 0;
   // Field positions in timing_and_buffer_clear
   localparam int IFC_B_TS  = 1;
   localparam int IFC_B_BC  = 0;
   // Reset values
   localparam logic [7:0] IFC_RST8   = 8'h00;
   localparam logic [7:0] IFC_RST_KEY = 8'h55;  // Chip reset key value
   // Unlock key bytes for words one to three, low then high
   localparam logic [7:0] IFC_K1L = 8'h00;
   localparam logic [7:0] IFC_K2L = 8'h0d;
   localparam logic [7:0] IFC_K3L = 8'hc3;
   localparam logic [7:0] IFC_K1H = 8'h04;
   localparam logic [7:0] IFC_K2H = 8'h09;
   localparam logic [7:0] IFC_K3H = 8'h40;
   // Operation select codes
   typedef enum logic [2:0] {
      IFC_OP_WRITE  = 3'b000,
      IFC_OP_ERASE  = 3'b001,
      IFC_OP_READ   = 3'b011,
      IFC_OP_UNLOCK = 3'b110
   } ifc_op_t;
   localparam logic [4:0] IFC_PAGE_LAST = 5'h1f;  // Last word offset in a page
   // Timing, in ns and derived cycles at 40 MHz
   localparam longint IFC_CLK_NS    = 25;
   localparam longint IFC_ER0_NS    = 3200000;  // 3.2 ms
   localparam longint IFC_WR0_NS    = 2200000;  // 2.2 ms
   localparam longint IFC_ER1_NS    = 3700000;  // 3.7 ms
   localparam longint IFC_WR1_NS    = 3000000;  // 3.0 ms
   localparam int IFC_ER0_CYC = int'((IFC_ER0_NS + IFC_CLK_NS - 1) / IFC_CLK_NS);
   localparam int IFC_WR0_CYC = int'((IFC_WR0_NS + IFC_CLK_NS - 1) / IFC_CLK_NS);
   localparam int IFC_ER1_CYC = int'((IFC_ER1_NS + IFC_CLK_NS - 1) / IFC_CLK_NS);
   localparam int IFC_WR1_CYC = int'((IFC_WR1_NS + IFC_CLK_NS - 1) / IFC_CLK_NS);
   localparam int IFC_UNL_CYC = 2000;   // Unlock window, plain default
   localparam int IFC_RD_CYC  = 4;      // Read access time
   localparam int IFC_CLR_CYC = 32;     // One cycle per buffer word
   // Wishbone request bundle
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [5:0]  adr;
      logic [31:0] dat;
   } ifc_wb_req_t;
   // Flash array command bundle
   typedef struct packed {
      logic        erase;
      logic        write;
      logic        read;
      logic [12:0] addr;
   } ifc_fl_cmd_t;
endpackage : ifc_pkg

//--- ifc_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Software cannot set enable flag, only clear
// - Decode operation select; other codes reserved
// - Erase/write only after successful unlock
// - Unlock trigger starts timer, self-clears at expiry
// - Program start runs operation, clears when done
// - Read blocked while read enable low
// - Read start runs read, clears when done
// - CPU stalled while operation runs
// - Key 55h on reset register resets chip
// - Timing select picks erase/write durations
// - Buffer clear self-clears when done
// - Upper six timing bits read zero
// - High byte write tags address, saturates page
// - Erase covers only tagged addresses
// - Erased word reads back zero
// - Timer expiry clears trigger regardless of key
// - Wrong key keeps disabled, right key enables
// - Clearing flag disables at once
// - High byte write loads buffer, bumps address
// - Buffer holds 32 words, page from address
module ifc_ctrl
   import ifc_pkg::*;
#(
   parameter int ER0_CYC = IFC_ER0_CYC,
   parameter int WR0_CYC = IFC_WR0_CYC,
   parameter int ER1_CYC = IFC_ER1_CYC,
   parameter int WR1_CYC = IFC_WR1_CYC,
   parameter int UNL_CYC = IFC_UNL_CYC
) (
   input  wire logic        clk_i,        // 40 MHz clock
   input  wire logic        rst_i,        // Synchronous reset
   input  wire logic        wb_cyc_i,     // Wishbone cycle
   input  wire logic        wb_stb_i,     // Wishbone strobe
   input  wire logic        wb_we_i,      // Write
   input  wire logic [3:0]  wb_sel_i,     // Byte lanes
   input  wire logic [5:0]  wb_adr_i,     // Byte address
   input  wire logic [31:0] wb_dat_i,     // Write data
   output logic [31:0]      wb_dat_o,     // Read data
   output logic             wb_ack_o,     // Acknowledge
   input  wire logic [15:0] fl_rdata_i,   // Flash array read word
   output logic             fl_erase_o,   // Erase strobe, tagged words
   output logic             fl_write_o,   // Write strobe, buffer contents
   output logic             fl_read_o,    // Read strobe
   output logic [12:0]      fl_addr_o,    // Flash address
   output logic [31:0]      fl_tag_o,     // Erase tags per word of page
   output logic [15:0]      fl_wbuf_o,    // Buffer word at address offset
   output logic [15:0]      rd_data_o,    // Last read word
   output logic             cpu_stall_o,  // CPU hold
   output logic             chip_rst_o    // Chip reset pulse
);
   // Sequencer states
   typedef enum logic [4:0] {
      IFC_S_IDLE = 5'b00001,
      IFC_S_ERS  = 5'b00010,
      IFC_S_WRT  = 5'b00100,
      IFC_S_RD   = 5'b01000,
      IFC_S_CLR  = 5'b10000
   } ifc_st_t;

   ifc_st_t     st_ff, nxt_st;          // Sequencer state
   logic        en_ff, trg_ff, ps_ff, re_ff, rs_ff, ts_ff, bc_ff;
   logic [2:0]  op_ff;                  // Operation select
   logic [7:0]  key_ff;                 // Chip reset key register
   logic [12:0] adr_ff;                 // Flash address pair
   logic [7:0]  dat_ff [8];             // Data words 0..3, low/high
   logic [15:0] wbuf_ff [32];           // Page write buffer
   logic [31:0] tag_ff;                 // Tagged word flags
   logic [21:0] cnt_ff;                 // Operation duration counter
   logic [10:0] ucnt_ff;                // Unlock window counter
   logic [15:0] rd_ff;                  // Read data
   logic        ack_ff;                 // Bus ack
   logic        rst_ff;                 // Chip reset pulse
   logic [4:0]  clr_ff;                 // Clear index

   // True for the eight data byte registers; shared by decode and read mux
   function automatic logic w_in_data(input logic [3:0] i);
      return (i >= IFC_IDX_D0L) && (i <= IFC_IDX_D3H);
   endfunction : w_in_data

   // Request decode
   wire         req    = wb_cyc_i & wb_stb_i & ~ack_ff;
   wire         wr     = req & wb_we_i & wb_sel_i[0];
   wire [3:0]   idx    = wb_adr_i[5:2];
   wire [7:0]   wd     = wb_dat_i[7:0];
   wire         w_fc   = wr & (idx == IFC_IDX_FC);
   wire         w_rk   = wr & (idx == IFC_IDX_RK);
   wire         w_tb   = wr & (idx == IFC_IDX_TB);
   wire         w_al   = wr & (idx == IFC_IDX_AL);
   wire         w_ah   = wr & (idx == IFC_IDX_AH);
   wire         w_d0h  = wr & (idx == IFC_IDX_D0L + 4'h1);
   wire         w_dat  = wr & w_in_data(idx);
   wire [2:0]   didx   = 3'(idx - IFC_IDX_D0L);
   wire         idle   = (st_ff == IFC_S_IDLE);
   // Start conditions; illegal starts are dropped
   wire         ps_set = w_fc & wd[IFC_B_PS] & idle;
   wire         go_ers = ps_set & en_ff & (wd[IFC_B_MH:IFC_B_ML] == IFC_OP_ERASE);
   wire         go_wrt = ps_set & en_ff & (wd[IFC_B_MH:IFC_B_ML] == IFC_OP_WRITE);
   wire         go_rd  = w_fc & wd[IFC_B_RS] & idle & (re_ff | wd[IFC_B_RE])
                         & (wd[IFC_B_MH:IFC_B_ML] == IFC_OP_READ);
   wire         go_unl = w_fc & wd[IFC_B_TRG] & ~trg_ff
                         & (wd[IFC_B_MH:IFC_B_ML] == IFC_OP_UNLOCK);
   wire         go_clr = w_tb & wd[IFC_B_BC] & idle;
   // Duration select
   wire [21:0]  er_len = ts_ff ? 22'(ER1_CYC) : 22'(ER0_CYC);
   wire [21:0]  wr_len = ts_ff ? 22'(WR1_CYC) : 22'(WR0_CYC);
   wire         done   = (cnt_ff == 22'h000001);
   wire         u_end  = trg_ff & (ucnt_ff == 11'h001);
   // Key check across data words one to three
   wire         key_ok = (dat_ff[2] == IFC_K1L) & (dat_ff[4] == IFC_K2L)
                       & (dat_ff[6] == IFC_K3L) & (dat_ff[3] == IFC_K1H)
                       & (dat_ff[5] == IFC_K2H) & (dat_ff[7] == IFC_K3H);
   // Address increment with page saturation
   wire [12:0]  adr_inc = (adr_ff[4:0] == IFC_PAGE_LAST) ? adr_ff : adr_ff + 13'h0001;

   // Next-state logic
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         IFC_S_IDLE: begin
            if (go_ers)      nxt_st = IFC_S_ERS;
            else if (go_wrt) nxt_st = IFC_S_WRT;
            else if (go_rd)  nxt_st = IFC_S_RD;
            else if (go_clr) nxt_st = IFC_S_CLR;
         end
         IFC_S_ERS, IFC_S_WRT, IFC_S_RD: begin
            if (done) nxt_st = IFC_S_IDLE;
         end
         IFC_S_CLR: begin
            if (clr_ff == IFC_PAGE_LAST) nxt_st = IFC_S_IDLE;
         end
         default: nxt_st = IFC_S_IDLE;
      endcase
   end

   // State and operation counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff  <= IFC_S_IDLE;
         cnt_ff <= 22'h0;
      end else begin
         st_ff <= nxt_st;
         // Counter is loaded at launch and runs down to zero; done is flagged at one
         if (go_ers)      cnt_ff <= er_len;
         else if (go_wrt) cnt_ff <= wr_len;
         else if (go_rd)  cnt_ff <= 22'(IFC_RD_CYC);
         else if (cnt_ff != 22'h0) cnt_ff <= cnt_ff - 22'h000001;
      end
   end

   // Control register bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_ff <= 1'b0;
         op_ff <= 3'b000;
         trg_ff <= 1'b0;
         ps_ff <= 1'b0;
         re_ff <= 1'b0;
         rs_ff <= 1'b0;
         ts_ff <= 1'b0;
         ucnt_ff <= 11'h0;
      end else begin
         // Hardware set beats software clear
         if (u_end & key_ok)                      en_ff <= 1'b1;
         else if (w_fc & ~wd[IFC_B_EN])           en_ff <= 1'b0;
         // Mode, read enable and timing select are plain software fields
         if (w_fc) op_ff <= wd[IFC_B_MH:IFC_B_ML];
         if (w_fc) re_ff <= wd[IFC_B_RE];
         if (w_tb) ts_ff <= wd[IFC_B_TS];
         // Unlock window timer
         if (go_unl) begin
            trg_ff  <= 1'b1;
            ucnt_ff <= 11'(UNL_CYC);
         end else if (u_end) begin
            trg_ff  <= 1'b0;
            ucnt_ff <= 11'h0;
         end else if (trg_ff) begin
            ucnt_ff <= ucnt_ff - 11'h001;
         end
         // Start bits self-clear on completion
         if (go_ers | go_wrt)                     ps_ff <= 1'b1;
         else if (done & (st_ff != IFC_S_RD))     ps_ff <= 1'b0;
         if (go_rd)                               rs_ff <= 1'b1;
         else if (done & (st_ff == IFC_S_RD))     rs_ff <= 1'b0;
      end
   end

   // Address, data words, key register, chip reset pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         adr_ff <= 13'h0;
         key_ff <= IFC_RST8;
         rst_ff <= 1'b0;
         for (int i = 0; i < 8; i++) dat_ff[i] <= IFC_RST8;
      end else begin
         // One-cycle reset pulse; the key value itself is still stored
         rst_ff <= w_rk & (wd == IFC_RST_KEY);
         if (w_rk) key_ff <= wd;
         if (w_dat) dat_ff[didx] <= wd;
         if (w_al)       adr_ff[7:0]  <= wd;
         else if (w_ah)  adr_ff[12:8] <= wd[4:0];
         else if (w_d0h) adr_ff <= adr_inc;
      end
   end

   // Write buffer, tags and clear engine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tag_ff <= 32'h0;
         clr_ff <= 5'h0;
         bc_ff  <= 1'b0;
         for (int i = 0; i < 32; i++) wbuf_ff[i] <= 16'h0000;
      end else begin
         if (go_clr) begin
            bc_ff  <= 1'b1;
            clr_ff <= 5'h0;
         end else if (st_ff == IFC_S_CLR) begin
            wbuf_ff[clr_ff] <= 16'h0000;
            clr_ff <= clr_ff + 5'h01;
            if (clr_ff == IFC_PAGE_LAST) bc_ff <= 1'b0;
         end
         // Loads are ignored while locked, but the address still advances
         if (w_d0h & en_ff) begin
            wbuf_ff[adr_ff[4:0]] <= {wd, dat_ff[0]};
            tag_ff[adr_ff[4:0]]  <= 1'b1;
         end
         // Tags and buffer drop after an erase or write finishes
         if (done & (st_ff != IFC_S_RD)) begin
            tag_ff <= 32'h0;
            for (int i = 0; i < 32; i++) wbuf_ff[i] <= 16'h0000;
         end
      end
   end

   // Read capture; array returns 0000h for erased words
   always_ff @(posedge clk_i) begin
      if (rst_i) rd_ff <= 16'h0000;
      else if (done & (st_ff == IFC_S_RD)) rd_ff <= fl_rdata_i;
   end

   // Read mux; timing register upper bits zero
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00;
      case (idx)
         IFC_IDX_FC: rmux = {en_ff, op_ff, trg_ff, ps_ff, re_ff, rs_ff};
         IFC_IDX_RK: rmux = key_ff;
         IFC_IDX_TB: rmux = {6'h00, ts_ff, bc_ff};
         IFC_IDX_AL: rmux = adr_ff[7:0];
         IFC_IDX_AH: rmux = {3'b000, adr_ff[12:8]};
         default:    rmux = w_in_data(idx) ? dat_ff[3'(idx - IFC_IDX_D0L)] : 8'h00;
      endcase
   end

   // Bus answer one cycle after the request; unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff   <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         ack_ff   <= req;
         wb_dat_o <= {24'h0, rmux};
      end
   end

   assign wb_ack_o    = ack_ff;
   assign fl_erase_o  = (st_ff == IFC_S_ERS);
   assign fl_write_o  = (st_ff == IFC_S_WRT);
   assign fl_read_o   = (st_ff == IFC_S_RD);
   assign fl_addr_o   = adr_ff;
   assign fl_tag_o    = tag_ff;
   assign fl_wbuf_o   = wbuf_ff[adr_ff[4:0]];
   assign rd_data_o   = rd_ff;
   assign cpu_stall_o = ~idle & (st_ff != IFC_S_CLR);
   assign chip_rst_o  = rst_ff;

   // Stall covers exactly the running operation
   stall_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cpu_stall_o == (ps_ff | rs_ff)) else $error("stall mismatch");

   // Enable flag never rises except at unlock end
   en_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(en_ff) |-> $past(u_end)) else $error("enable rose wrongly");

   // Trigger drop only at timer end
   trg_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(trg_ff) |-> $past(u_end)) else $error("trigger fell early");

   // Clearing enable takes effect next cycle
   en_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (w_fc & ~wd[IFC_B_EN] & ~u_end) |=> ~en_ff) else $error("disable late");

   // Chip reset follows key write
   key_rst_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (w_rk & (wd == IFC_RST_KEY)) |=> chip_rst_o) else $error("no chip reset");

   // No erase or write while locked
   lock_op_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ps_set & ~en_ff) |=> ~ps_ff) else $error("locked start accepted");

   // Read lasts fixed cycles then clears
   rd_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_rd |=> fl_read_o [*4] ##1 ~rs_ff) else $error("read timing");

   // Buffer clear finishes in 32 cycles
   clr_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_clr |-> ##[1:33] ~bc_ff) else $error("clear stuck");

   // Upper timing bits read zero
   tb_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (req & ~wb_we_i & (idx == IFC_IDX_TB)) |=> (wb_dat_o[7:2] == 6'h00))
      else $error("reserved bits set");

   // Address saturates at page end
   adr_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (w_d0h & (adr_ff[4:0] == IFC_PAGE_LAST)) |=> $stable(adr_ff))
      else $error("address wrapped");

   // Unlock write arms the trigger and its timer
   trg_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_unl |=> trg_ff) else $error("trigger not armed");

   // Timer expiry drops the trigger whatever the key
   trg_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
      u_end |=> ~trg_ff) else $error("trigger kept");

   // Correct key at expiry sets the flag
   key_good_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (u_end & key_ok) |=> en_ff) else $error("good key ignored");

   // Wrong key leaves a clear flag clear
   key_bad_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (u_end & ~key_ok & ~en_ff) |=> ~en_ff) else $error("bad key accepted");

   // Launch raises the matching strobe and the start bit
   ers_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_ers |=> (fl_erase_o & ps_ff)) else $error("erase not launched");

   wrt_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_wrt |=> (fl_write_o & ps_ff)) else $error("write not launched");

   // Counter is loaded with the selected duration
   ers_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_ers |=> (cnt_ff == $past(er_len))) else $error("erase length");

   wrt_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_wrt |=> (cnt_ff == $past(wr_len))) else $error("write length");

   // Start bit falls only on completion
   ps_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(ps_ff) |-> $past(done)) else $error("start bit dropped early");

   // Read start without read enable is dropped
   rd_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (w_fc & idle & wd[IFC_B_RS] & ~wd[IFC_B_RE] & ~re_ff) |=> ~rs_ff)
      else $error("read not gated");

   // Buffer clear shows busy at once
   bc_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
      go_clr |=> bc_ff) else $error("clear not started");

   // Any value written to the key register is stored
   key_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
      w_rk |=> (key_ff == $past(wd))) else $error("key not stored");

   // Buffer load bumps the address inside the page
   adr_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (w_d0h & (adr_ff[4:0] != IFC_PAGE_LAST)) |=> (adr_ff == $past(adr_ff) + 13'h0001))
      else $error("address not bumped");

   // Start with a code other than erase or write is dropped
   bad_op_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ps_set & (wd[IFC_B_MH:IFC_B_ML] != IFC_OP_ERASE)
       & (wd[IFC_B_MH:IFC_B_ML] != IFC_OP_WRITE)) |=> ~ps_ff)
      else $error("illegal start accepted");
endmodule : ifc_ctrl

//--- iap_flash_control_unlock_tb.sv
`timescale 1ns/1ps
module iap_flash_control_unlock_tb
   import ifc_pkg::*;
   ;
   // Short operation lengths keep the run well under the cycle budget
   localparam int ER0 = 30;
   localparam int WR0 = 20;
   localparam int ER1 = 40;
   localparam int WR1 = 25;
   localparam int UNL = 40;

   logic        clk_i;         // 40 MHz bench clock
   logic        rst_i;         // Synchronous reset, active high
   ifc_wb_req_t req;           // Wishbone request bundle from the bench
   logic [15:0] fl_rdata_i;    // Flash array word seen by a read
   logic [31:0] wb_dat_o;      // Read data
   logic        wb_ack_o;      // Acknowledge
   logic        fl_erase_o;    // Erase strobe
   logic        fl_write_o;    // Write strobe
   logic        fl_read_o;     // Read strobe
   logic [12:0] fl_addr_o;     // Flash address
   logic [31:0] fl_tag_o;      // Erase tags
   logic [15:0] fl_wbuf_o;     // Buffer word at current offset
   logic [15:0] rd_data_o;     // Last read word
   logic        cpu_stall_o;   // CPU hold
   logic        chip_rst_o;    // Chip reset pulse
   int          fail_count;    // Mismatches seen
   int          cmp_count;     // Comparisons made
   int          er_cnt;        // Cycles with erase strobe high
   int          wr_cnt;        // Cycles with write strobe high
   int          rd_cnt;        // Cycles with read strobe high
   int          stall_cnt;     // Cycles with CPU held
   int          crst_cnt;      // Chip reset pulses
   int          m_en;          // Model of the erase/write enabled flag
   logic [31:0] rd;            // Last bus read value
   logic [15:0] dat;           // Last word loaded into the buffer
   logic [7:0]  key [6];       // Unlock pattern in bus order

   ifc_ctrl #(.ER0_CYC(ER0), .WR0_CYC(WR0), .ER1_CYC(ER1), .WR1_CYC(WR1),
              .UNL_CYC(UNL)) ifc_ctrl_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
      .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fl_rdata_i(fl_rdata_i),
      .fl_erase_o(fl_erase_o), .fl_write_o(fl_write_o), .fl_read_o(fl_read_o),
      .fl_addr_o(fl_addr_o), .fl_tag_o(fl_tag_o), .fl_wbuf_o(fl_wbuf_o),
      .rd_data_o(rd_data_o), .cpu_stall_o(cpu_stall_o), .chip_rst_o(chip_rst_o));

   // Free-running clock, half period 12.5 ns
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Activity monitor; sees pre-edge values so no race with the design
   always @(posedge clk_i) begin
      if (fl_erase_o === 1'b1) er_cnt++;
      if (fl_write_o === 1'b1) wr_cnt++;
      if (fl_read_o === 1'b1) rd_cnt++;
      if (cpu_stall_o === 1'b1) stall_cnt++;
      if (chip_rst_o === 1'b1) crst_cnt++;
   end

   // Verdict and end of run, the single exit point
   task final_report;
      if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report

   // Case-equality compare so an unknown never matches
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One classic cycle; ack is sampled at the rising edge, as the slave sees it
   task xfer(input logic we, input logic [3:0] idx, input logic [7:0] d,
             output logic [31:0] q);
      int n;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {idx, 2'b00},
               dat: {24'h0, d}};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         final_report();
      end
      q = wb_dat_o;
      req <= '0;  // Released at the edge that sampled ack
   endtask : xfer

   task wr(input logic [3:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d, rd);
   endtask : wr

   task rdchk(input logic [3:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00, rd);
      check(rd, {24'h0, exp});
   endtask : rdchk

   // Poll until self-clearing bits drop; bounded, a hang ends the run
   task poll(input logic [3:0] idx, input logic [7:0] mask);
      int n;
      n = 0;
      do begin
         xfer(1'b0, idx, 8'h00, rd);
         n++;
      end while ((rd[7:0] & mask) !== 8'h00 && n < 200);
      if (n >= 200) begin
         fail_count++;
         final_report();
      end
   endtask : poll

   // Counters zeroed away from the sampling edge
   task clr;
      @(negedge clk_i);
      er_cnt = 0;
      wr_cnt = 0;
      rd_cnt = 0;
      stall_cnt = 0;
      crst_cnt = 0;
   endtask : clr

   // Unlock attempt; a bad pattern flips one bit of the last byte
   task unlock(input int good);
      wr(IFC_IDX_FC, 8'h68);
      for (int i = 0; i < 6; i++) wr(4'(7 + i), key[i] ^ 8'((good == 0) && (i == 5)));
      poll(IFC_IDX_FC, 8'h08);
      m_en = good;
      rdchk(IFC_IDX_FC, {1'(m_en), 7'h60});
   endtask : unlock

   // Tag offsets 30 and 31; the second and third loads saturate at the page end
   task tag3;
      wr(IFC_IDX_AL, 8'h1e);
      wr(IFC_IDX_AH, 8'h00);
      repeat (3) begin
         dat = 16'($urandom);
         wr(IFC_IDX_D0L, dat[7:0]);
         wr(4'(IFC_IDX_D0L + 1), dat[15:8]);
      end
      check(32'(fl_addr_o), 32'h0000001f);
      check(fl_tag_o, 32'hc0000000);
      check(32'(fl_wbuf_o), 32'(dat));
      rdchk(IFC_IDX_AL, 8'h1f);
   endtask : tag3

   // Expected duration from the timing select and the operation
   function int dur_of(input int ts, input int k);
      return (ts != 0) ? ((k != 0) ? WR1 : ER1) : ((k != 0) ? WR0 : ER0);
   endfunction : dur_of

   // Main sequence
   initial begin
      rst_i = 1'b1;
      req = '0;
      fl_rdata_i = 16'h0000;
      fail_count = 0;
      cmp_count = 0;
      m_en = 0;
      key = '{IFC_K1L, IFC_K1H, IFC_K2L, IFC_K2H, IFC_K3L, IFC_K3H};
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      void'($urandom(32'hea4b1ff4));
      // Reset values of every word, plus one unmapped word
      for (int i = 0; i <= 13; i++) rdchk(4'(i), IFC_RST8);
      // Software cannot set the enabled flag; start while locked is dropped
      clr();
      wr(IFC_IDX_FC, 8'h84);
      rdchk(IFC_IDX_FC, 8'h00);
      check(32'(wr_cnt + stall_cnt), 32'h0);
      unlock(0);
      unlock(1);
      // Buffer clear runs without holding the CPU
      tag3();
      clr();
      wr(IFC_IDX_TB, 8'h01);
      poll(IFC_IDX_TB, 8'h01);
      check(32'(fl_wbuf_o), 32'h0);
      check(32'(stall_cnt), 32'h0);
      // Erase then write under both timing selections
      for (int ts = 0; ts < 2; ts++) begin
         for (int k = 0; k < 2; k++) begin
            wr(IFC_IDX_TB, {6'h3f, 1'(ts), 1'b0});
            rdchk(IFC_IDX_TB, {6'h00, 1'(ts), 1'b0});
            tag3();
            clr();
            wr(IFC_IDX_FC, {1'b1, (k != 0) ? IFC_OP_WRITE : IFC_OP_ERASE, 4'h4});
            poll(IFC_IDX_FC, 8'h04);
            check(32'((k != 0) ? wr_cnt : er_cnt), 32'(dur_of(ts, k)));
            check(32'((k != 0) ? er_cnt : wr_cnt), 32'h0);
            check(32'(stall_cnt), 32'(dur_of(ts, k)));
            check(fl_tag_o, 32'h0);
            rdchk(IFC_IDX_FC, {1'(m_en), (k != 0) ? 3'b000 : 3'b001, 4'h0});
         end
      end
      // Read blocked without read enable, then a real read
      clr();
      wr(IFC_IDX_FC, 8'hb1);
      repeat (6) @(negedge clk_i);
      check(32'(rd_cnt + stall_cnt), 32'h0);
      @(posedge clk_i);
      fl_rdata_i <= 16'($urandom);
      wr(IFC_IDX_FC, 8'hb2);
      wr(IFC_IDX_FC, 8'hb3);
      poll(IFC_IDX_FC, 8'h01);
      check(32'(rd_cnt), 32'(IFC_RD_CYC));
      check(32'(rd_data_o), 32'(fl_rdata_i));
      check(32'(stall_cnt), 32'(IFC_RD_CYC));
      // Reserved codes start nothing
      clr();
      for (int c = 2; c < 8; c++) begin
         if (c != 3 && c != 6) wr(IFC_IDX_FC, {1'b1, 3'(c), 4'h4});
      end
      repeat (4) @(negedge clk_i);
      check(32'(er_cnt + wr_cnt + rd_cnt + stall_cnt), 32'h0);
      // Clearing the flag disables at once, no key needed
      wr(IFC_IDX_FC, 8'h00);
      rdchk(IFC_IDX_FC, 8'h00);
      clr();
      wr(IFC_IDX_FC, 8'h04);
      repeat (4) @(negedge clk_i);
      check(32'(wr_cnt + stall_cnt), 32'h0);
      // Only the key value resets the chip; others are stored
      clr();
      wr(IFC_IDX_RK, 8'h54);
      rdchk(IFC_IDX_RK, 8'h54);
      wr(IFC_IDX_RK, IFC_RST_KEY);
      repeat (3) @(negedge clk_i);
      check(32'(crst_cnt), 32'h1);
      final_report();
   end
endmodule : iap_flash_control_unlock_tb
